// file: design/udcp_port.sv
//
// Overview of operation
// [R1] Differential select picks paired reference input.
// [R2] Power-down stops logic, PLL may stay. Here profile-change and strobe tuning word loads still run during power-down.
// [R3] High reset input forces default state.
// [R4] Lock output follows PLL lock live.
// [R5] Overflow output shows interpolator overflow.
// [R6] Shared pin drives data clock outside tone.
// [R7] Tone mode: pin is update strobe input.
// [R8] Profile switch activates tuning word directly.
// [R9] Gate low substitutes zeros for I/Q.
// [R10] First word after gate is I.
// [R11] Three modes, quadrature by default.
// [R12] Mode chosen only by control register.
// [R13] Sinc and scale usable every mode.
// [R14] Quadrature: I and Q issued together.
// [R15] Host words align to data clock.
// [R16] Modulator multiplies I,Q by carriers.
// [R17] Tone mode: cosine source, paths off.
// [R18] DAC mode: Q path and DDS off.
// [R19] DAC mode: one I word per clock.
// [R20] DAC mode: baseband, no modulation.
// [R21] Host keeps gate even clock intervals.
// [R22] Host words are 14-bit twos complement.
// [R23] Update happens on strobe rising edge.
// [R24] Data clock continuous, optionally lock-qualified.
// [R25] Pairing restarts at I on gate.
// [R26] Pin direction changes only with mode.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "udcp_consts.svh"

module udcp_port
  import udcp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Device pins
  input wire logic hw_reset_i,
  input wire logic diff_ref_clock_in_select_i,
  input wire logic digital_powerdown_i,
  input wire logic pll_lock_raw_i,
  input wire logic interp_overflow_raw_i,
  input wire logic transmit_gate_i,
  input wire logic [1:0] profile_select_i,
  input wire logic [`UDCP_DATA_W-1:0] parallel_data_bus_i,
  input wire logic data_clock_or_update_pin_i,
  output logic data_clock_or_update_pin_o,
  output logic data_clock_or_update_pin_oe_o,
  output logic pll_lock_o,
  output logic interp_overflow_o,
  output logic ref_clock_in_diff_mode_o,
  output logic pll_keep_o,
  // Register port
  input wire logic [`UDCP_ADDR_W-1:0] reg_addr_i,
  input wire logic [`UDCP_REG_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`UDCP_REG_W-1:0] reg_rdata_o,
  // Sample stream to the signal path
  output logic sample_valid_o,
  output logic [`UDCP_DATA_W-1:0] sample_i_o,
  output logic [`UDCP_DATA_W-1:0] sample_q_o,
  output logic i_path_en_o,
  output logic q_path_en_o,
  output logic dds_en_o,
  output logic modulator_en_o,
  output logic post_stages_en_o,
  output logic [`UDCP_TW_W-1:0] acc_tuning_word_o,
  output logic tw_load_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic hw_reset_s, pd_s, lock_s, ovf_s, gate_s, gate_rise, fud_rise;
  logic diff_s, ps0_s, ps1_s;

  udcp_sync u_sync_rst (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .async_i(hw_reset_i), .level_o(hw_reset_s), .rise_o());
  udcp_sync u_sync_pd (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .async_i(digital_powerdown_i), .level_o(pd_s), .rise_o());
  udcp_sync u_sync_lock (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .async_i(pll_lock_raw_i), .level_o(lock_s), .rise_o());
  udcp_sync u_sync_ovf (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .async_i(interp_overflow_raw_i), .level_o(ovf_s), .rise_o());
  udcp_sync u_sync_gate (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .async_i(transmit_gate_i), .level_o(gate_s), .rise_o(gate_rise));
  udcp_sync u_sync_fud (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .async_i(data_clock_or_update_pin_i), .level_o(), .rise_o(fud_rise));
  udcp_sync u_sync_diff (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .async_i(diff_ref_clock_in_select_i), .level_o(diff_s), .rise_o());
  udcp_sync u_sync_ps0 (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .async_i(profile_select_i[0]), .level_o(ps0_s), .rise_o());
  udcp_sync u_sync_ps1 (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .async_i(profile_select_i[1]), .level_o(ps1_s), .rise_o());

  // Data bus is sampled twice as well; the host holds it stable around the clock edge.
  logic [`UDCP_DATA_W-1:0] data_m_q, data_s_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_m_q <= '0;
      data_s_q <= '0;
    end else begin
      data_m_q <= parallel_data_bus_i;
      data_s_q <= data_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [`UDCP_REG_W-1:0] ctrl_q;
  logic [`UDCP_DIV_W-1:0] div_q;
  logic [`UDCP_TW_W-1:0] tw_q [4];
  logic [`UDCP_TW_W-1:0] acc_tw_q;
  logic soft_rst;
  udcp_mode_t mode;
  logic lock_qual, run_digital;
  logic pclk_oe_q, pair_q_q;
  logic [2:0] oe_hist_q;

  // The hardware reset pin clears state synchronously, like a second reset.
  assign soft_rst = hw_reset_s; // see [R3]
  assign run_digital = !pd_s; // see [R2]

  // Unknown mode codes fall back to quadrature modulation.
  always_comb begin
    case (ctrl_q[`UDCP_CTRL_MODE_LSB +: `UDCP_MODE_W]) // see [R12]
      2'h1: mode = UDCP_MODE_TONE;
      2'h2: mode = UDCP_MODE_IDAC;
      default: mode = UDCP_MODE_QUAD; // see [R11]
    endcase
  end

  // Control, divider and profile tuning words written by software.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `UDCP_CTRL_RST;
      div_q <= `UDCP_DIV_RST;
      for (int k = 0; k < 4; k++) tw_q[k] <= `UDCP_TW_RST;
    end else if (soft_rst) begin
      ctrl_q <= `UDCP_CTRL_RST; // see [R3]
      div_q <= `UDCP_DIV_RST;
      for (int k = 0; k < 4; k++) tw_q[k] <= `UDCP_TW_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `UDCP_REG_CTRL) begin
        ctrl_q <= reg_wdata_i;
      end else if (reg_addr_i == `UDCP_REG_DIV) begin
        div_q <= reg_wdata_i[`UDCP_DIV_W-1:0];
      end else if (reg_addr_i[3:2] == 2'b01) begin
        tw_q[reg_addr_i[1:0]] <= reg_wdata_i;
      end
    end
  end

  // Read data stands one cycle after the read strobe only.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `UDCP_REG_CTRL) begin
        reg_rdata_o <= ctrl_q;
      end else if (reg_addr_i == `UDCP_REG_STATUS) begin
        reg_rdata_o <= {26'h0, pclk_oe_q, pair_q_q, gate_s, pd_s, ovf_s, lock_s};
      end else if (reg_addr_i == `UDCP_REG_DIV) begin
        reg_rdata_o <= {24'h0, div_q};
      end else if (reg_addr_i[3:2] == 2'b01) begin
        reg_rdata_o <= tw_q[reg_addr_i[1:0]];
      end else if (reg_addr_i == `UDCP_REG_ACC_TW) begin
        reg_rdata_o <= acc_tw_q;
      end else begin
        reg_rdata_o <= '0;
      end
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Status pins and reference select
  // ----------------------------------------------------------------
  assign pll_lock_o = lock_s; // see [R4]
  assign interp_overflow_o = ovf_s; // see [R5]
  assign ref_clock_in_diff_mode_o = diff_s; // see [R1]
  assign pll_keep_o = ctrl_q[`UDCP_CTRL_PLLKEEP_BIT]; // see [R2]

  // ----------------------------------------------------------------
  // Shared pin and data clock
  // ----------------------------------------------------------------
  logic pclk, pclk_rise, div_run;

  // Clock runs while powered, out of hardware reset and not in tone mode, gated by lock if asked.
  assign lock_qual = !ctrl_q[`UDCP_CTRL_LOCKQ_BIT] || lock_s; // see [R24]
  assign div_run = run_digital && !soft_rst && (mode != UDCP_MODE_TONE) && lock_qual;

  udcp_clkdiv u_clkdiv (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(div_run),
    .half_i(div_q),
    .pclk_o(pclk),
    .rise_o(pclk_rise)
  );

  // Direction follows only the mode, so gate or lock never flips it.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pclk_oe_q <= 1'b1;
    end else begin
      pclk_oe_q <= (mode != UDCP_MODE_TONE); // see [R6] [R26]
    end
  end

  // The last data clock edges still sit in the strobe synchroniser after the turn,
  // so strobe edges count only once the pin has been an input for three cycles.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_hist_q <= 3'h7;
    end else begin
      oe_hist_q <= {oe_hist_q[1:0], pclk_oe_q}; // see [R7]
    end
  end

  assign data_clock_or_update_pin_o = pclk_oe_q & pclk; // see [R6]
  assign data_clock_or_update_pin_oe_o = pclk_oe_q;

  // ----------------------------------------------------------------
  // Word assembler
  // ----------------------------------------------------------------
  logic [`UDCP_DATA_W-1:0] hold_i_q;
  logic take;

  // A word is latched on each internal data clock rising edge while gated, except in the cycle the gate rise is seen.
  assign take = pclk_rise && gate_s && !gate_rise; // see [R15] [R19]

  // Pairing restarts at I on every gate rise; zeros flow while gate is low.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pair_q_q <= 1'b0;
      hold_i_q <= '0;
      sample_valid_o <= 1'b0;
      sample_i_o <= '0;
      sample_q_o <= '0;
    end else if (soft_rst || !run_digital || !gate_s || gate_rise) begin
      pair_q_q <= 1'b0; // see [R10] [R25]
      hold_i_q <= '0;
      sample_valid_o <= pclk_rise && run_digital && !soft_rst; // see [R9]
      sample_i_o <= '0;
      sample_q_o <= '0;
    end else if (mode == UDCP_MODE_QUAD) begin
      sample_valid_o <= 1'b0;
      if (take && !pair_q_q) begin
        hold_i_q <= data_s_q; // see [R10]
        pair_q_q <= 1'b1;
      end else if (take) begin
        sample_i_o <= hold_i_q; // see [R14]
        sample_q_o <= data_s_q;
        sample_valid_o <= 1'b1;
        pair_q_q <= 1'b0;
      end
    end else if (mode == UDCP_MODE_IDAC) begin
      sample_valid_o <= take; // see [R19] [R20]
      pair_q_q <= 1'b0;
      if (take) begin
        sample_i_o <= data_s_q;
        sample_q_o <= '0; // see [R18]
      end
    end else begin
      sample_valid_o <= 1'b0; // see [R17]
      sample_i_o <= '0;
      sample_q_o <= '0;
    end
  end

  // Path enables handed to the filter, DDS and modulator stages.
  assign i_path_en_o = run_digital && (mode != UDCP_MODE_TONE); // see [R17]
  assign q_path_en_o = run_digital && (mode == UDCP_MODE_QUAD); // see [R14] [R18]
  assign dds_en_o = run_digital && (mode != UDCP_MODE_IDAC); // see [R18]
  assign modulator_en_o = run_digital && (mode == UDCP_MODE_QUAD); // see [R16] [R20]
  assign post_stages_en_o = run_digital; // see [R13]

  // ----------------------------------------------------------------
  // Tuning word transfer
  // ----------------------------------------------------------------
  logic [1:0] prof_q;
  logic [1:0] prof_now;
  assign prof_now = {ps1_s, ps0_s};

  // Profile changes load at once; in tone mode the strobe edge loads too.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prof_q <= 2'h0;
      acc_tw_q <= `UDCP_TW_RST;
      tw_load_o <= 1'b0;
    end else if (soft_rst) begin
      prof_q <= prof_now;
      acc_tw_q <= `UDCP_TW_RST;
      tw_load_o <= 1'b0;
    end else begin
      prof_q <= prof_now;
      tw_load_o <= 1'b0;
      if (prof_now != prof_q) begin
        acc_tw_q <= tw_q[prof_now]; // see [R8]
        tw_load_o <= 1'b1;
      end else if (fud_rise && mode == UDCP_MODE_TONE && !pclk_oe_q && oe_hist_q == 3'h0) begin
        acc_tw_q <= tw_q[prof_now]; // see [R7] [R23]
        tw_load_o <= 1'b1;
      end
    end
  end

  assign acc_tuning_word_o = acc_tw_q;

endmodule

`default_nettype wire

// file: design/udcp_consts.svh
`ifndef UDCP_CONSTS_SVH
`define UDCP_CONSTS_SVH

// ----------------------------------------------------------------
// Data widths and field positions
// ----------------------------------------------------------------
`define UDCP_DATA_W 14
`define UDCP_TW_W 32
`define UDCP_PROF_W 2
`define UDCP_MODE_W 2
`define UDCP_ADDR_W 4
`define UDCP_REG_W 32

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UDCP_REG_CTRL 4'h0
`define UDCP_REG_STATUS 4'h1
`define UDCP_REG_DIV 4'h2
`define UDCP_REG_TW0 4'h4
`define UDCP_REG_TW1 4'h5
`define UDCP_REG_TW2 4'h6
`define UDCP_REG_TW3 4'h7
`define UDCP_REG_ACC_TW 4'h8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define UDCP_CTRL_MODE_LSB 0
`define UDCP_CTRL_LOCKQ_BIT 2
`define UDCP_CTRL_PLLKEEP_BIT 3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define UDCP_CTRL_RST 32'h0000_0000
`define UDCP_DIV_RST 8'h04
`define UDCP_DIV_W 8
`define UDCP_TW_RST 32'h0000_0000

`endif

// file: design/udcp_pkg.sv
package udcp_pkg;

  // Operating modes; quadrature modulation is the reset mode.
  typedef enum logic [1:0] {
    UDCP_MODE_QUAD = 2'h0,
    UDCP_MODE_TONE = 2'h1,
    UDCP_MODE_IDAC = 2'h2
  } udcp_mode_t;

endpackage

// file: design/udcp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two flop synchroniser with a rising edge pulse taken from the second stage.
module udcp_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous level in, synchronous level and edge out
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // First stage feeds only the second stage.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;

endmodule

`default_nettype wire

// file: design/udcp_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none

`include "udcp_consts.svh"

// Divider that makes the parallel data clock and its rising edge enable.
module udcp_clkdiv (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic [`UDCP_DIV_W-1:0] half_i,
  // Outputs
  output logic pclk_o,
  output logic rise_o
);

  logic [`UDCP_DIV_W-1:0] cnt_q;
  logic [`UDCP_DIV_W-1:0] half_eff;

  // A half period of zero would wrap the compare limit to 255, so it counts as one.
  assign half_eff = (half_i == '0) ? `UDCP_DIV_W'(1) : half_i;
  assign rise_o = run_i && !pclk_o && (cnt_q >= half_eff - `UDCP_DIV_W'(1));

  // Toggle the clock every half period while running; park low otherwise.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      pclk_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q <= '0;
      pclk_o <= 1'b0;
    end else if (cnt_q >= half_eff - `UDCP_DIV_W'(1)) begin
      cnt_q <= '0;
      pclk_o <= ~pclk_o;
    end else begin
      cnt_q <= cnt_q + `UDCP_DIV_W'(1);
    end
  end

endmodule

`default_nettype wire

// file: verif/udcp_port_props.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// Checker on the port of the upconverter data port
// ----
module udcp_port_props (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Watched inputs
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic pll_lock_raw_i,
  input wire logic interp_overflow_raw_i,
  input wire logic diff_ref_clock_in_select_i,
  input wire logic transmit_gate_i,
  // Watched outputs
  input wire logic pll_lock_o,
  input wire logic interp_overflow_o,
  input wire logic ref_clock_in_diff_mode_o,
  input wire logic [31:0] reg_rdata_o,
  input wire logic sample_valid_o,
  input wire logic [13:0] sample_i_o,
  input wire logic [13:0] sample_q_o,
  input wire logic data_clock_or_update_pin_o,
  input wire logic data_clock_or_update_pin_oe_o,
  input wire logic [31:0] acc_tuning_word_o,
  input wire logic tw_load_o
);
  logic [1:0] rcnt_q;

  // Edges since reset; the two-flop copies hold stale values until filled.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rcnt_q <= 2'h0;
    end else if (rcnt_q != 2'h3) begin
      rcnt_q <= rcnt_q + 2'h1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_lock; rcnt_q == 2'h3 |-> pll_lock_o == $past(pll_lock_raw_i, 2); endproperty
  a_lock: assert property (p_lock) else $error("lock copy wrong");
  property p_ovf; rcnt_q == 2'h3 |-> interp_overflow_o == $past(interp_overflow_raw_i, 2); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow copy wrong");
  property p_diff; rcnt_q == 2'h3 |-> ref_clock_in_diff_mode_o == $past(diff_ref_clock_in_select_i, 2); endproperty
  a_diff: assert property (p_diff) else $error("clock select copy wrong");
  property p_rdata; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
  property p_valid; sample_valid_o |=> !sample_valid_o; endproperty
  a_valid: assert property (p_valid) else $error("sample pulse too long");
  property p_dir;
    $changed(data_clock_or_update_pin_oe_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2)
      || $past(reg_wr_i, 3);
  endproperty
  a_dir: assert property (p_dir) else $error("pin turned without a write");
  property p_pin; !data_clock_or_update_pin_oe_o |-> !data_clock_or_update_pin_o; endproperty
  a_pin: assert property (p_pin) else $error("pin driven while input");
  property p_acc; $changed(acc_tuning_word_o) |-> tw_load_o || $past(tw_load_o); endproperty
  a_acc: assert property (p_acc) else $error("tuning word moved unannounced");
  property p_zero;
    sample_valid_o && !$past(transmit_gate_i, 3) && !$past(transmit_gate_i, 4)
      && !$past(transmit_gate_i, 5) |-> sample_i_o == 14'h0 && sample_q_o == 14'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("data passed with gate low");
  c_data: cover property (sample_valid_o && sample_i_o != 14'h0);
  c_load: cover property (tw_load_o);
  c_tone: cover property (!data_clock_or_update_pin_oe_o);
endmodule

bind udcp_port udcp_port_props u_props (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i,
  .pll_lock_raw_i, .interp_overflow_raw_i, .diff_ref_clock_in_select_i, .transmit_gate_i,
  .pll_lock_o, .interp_overflow_o, .ref_clock_in_diff_mode_o, .reg_rdata_o, .sample_valid_o,
  .sample_i_o, .sample_q_o, .data_clock_or_update_pin_o, .data_clock_or_update_pin_oe_o,
  .acc_tuning_word_o, .tw_load_o);

`default_nettype wire

// file: verif/udcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// Baseband data source on the parallel port
// ----
module udcp_host_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data clock and burst request
  input wire logic pin_i,
  input wire logic go_i,
  input wire logic [3:0] n_words_i,
  // Port pins
  output logic gate_o,
  output logic [13:0] data_o
);
  logic prev_q;
  logic [3:0] k_q;

  // Words move just after a data clock rise; idle data toggles so no stale word lingers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
      gate_o <= 1'b0;
      k_q <= 4'h0;
      data_o <= 14'h0;
    end else begin
      prev_q <= pin_i;
      if (pin_i && !prev_q) begin
        if (gate_o && k_q + 4'h1 == n_words_i) begin
          gate_o <= 1'b0;
          data_o <= ~data_o;
        end else if (gate_o) begin
          k_q <= k_q + 4'h1;
          data_o <= 14'h3000 + {10'h0, k_q + 4'h1};
        end else if (go_i) begin
          gate_o <= 1'b1;
          k_q <= 4'h0;
          data_o <= 14'h3000;
        end else begin
          data_o <= ~data_o;
        end
      end
    end
  end
endmodule

`default_nettype wire

// file: verif/udcp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

`include "udcp_consts.svh"

module udcp_port_tb;
  import udcp_pkg::*;
  logic ref_clk_i, rst_n_i, hw_reset_i, diff_ref_clock_in_select_i, digital_powerdown_i;
  logic pll_lock_raw_i, interp_overflow_raw_i, transmit_gate_i, reg_wr_i, reg_rd_i, frequency_update_strobe, go;
  logic [1:0] profile_select_i;
  logic [13:0] parallel_data_bus_i, sample_i_o, sample_q_o;
  logic [3:0] reg_addr_i, nw;
  logic [31:0] reg_wdata_i, reg_rdata_o, acc_tuning_word_o;
  logic data_clock_or_update_pin_o, data_clock_or_update_pin_oe_o, pll_lock_o;
  logic interp_overflow_o, ref_clock_in_diff_mode_o, pll_keep_o, sample_valid_o, tw_load_o;
  logic i_path_en_o, q_path_en_o, dds_en_o, modulator_en_o, post_stages_en_o;
  logic [4:0] en_tab [4] = '{5'h1f, 5'h05, 5'h11, 5'h1f};
  int mismatches = 0, n_checks = 0, s = 0, cyc = 0, idac = 0, n;
  wire data_clock_or_update_pin_i = data_clock_or_update_pin_oe_o ?
    data_clock_or_update_pin_o : frequency_update_strobe;

  udcp_port dut_u (.ref_clk_i, .rst_n_i, .hw_reset_i, .diff_ref_clock_in_select_i,
    .digital_powerdown_i, .pll_lock_raw_i, .interp_overflow_raw_i, .transmit_gate_i,
    .profile_select_i, .parallel_data_bus_i, .data_clock_or_update_pin_i,
    .data_clock_or_update_pin_o, .data_clock_or_update_pin_oe_o, .pll_lock_o,
    .interp_overflow_o, .ref_clock_in_diff_mode_o, .pll_keep_o, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sample_valid_o, .sample_i_o, .sample_q_o,
    .i_path_en_o, .q_path_en_o, .dds_en_o, .modulator_en_o, .post_stages_en_o,
    .acc_tuning_word_o, .tw_load_o);
  udcp_host_model host_u (.clk_i(ref_clk_i), .rst_n_i, .pin_i(data_clock_or_update_pin_i),
    .go_i(go), .n_words_i(nw), .gate_o(transmit_gate_i), .data_o(parallel_data_bus_i));

  // ----
  // Clock, timeout and shared tasks
  // ----
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // A hang ends in the same closing report as a normal run.
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look just past that edge.
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, e);
  endtask

  task automatic waitc(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask

  task automatic per(input int e);
    realtime t;
    @(posedge data_clock_or_update_pin_o);
    t = $realtime;
    @(posedge data_clock_or_update_pin_o);
    n = int'(($realtime - t) / 4.0);
    check(n, e);
  endtask

  // One gated burst of nw words, then the count of data samples seen.
  task automatic burst(input logic [3:0] w, input int e);
    s = 0;
    nw <= w;
    go <= 1'b1;
    @(posedge transmit_gate_i);
    go <= 1'b0;
    @(negedge transmit_gate_i);
    waitc(20);
    check(s, e);
  endtask

  // Samples are read on the falling edge, well clear of the design's updates.
  always @(negedge ref_clk_i) begin
    if (sample_valid_o === 1'b1 && sample_i_o !== 14'h0) begin
      if (idac != 0) begin
        check(sample_i_o, 14'h3000 + s);
        check(sample_q_o, 0);
      end else begin
        check(sample_i_o, 14'h3000 + 2 * s);
        check(sample_q_o, 14'h3001 + 2 * s);
      end
      s++;
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    {rst_n_i, hw_reset_i, diff_ref_clock_in_select_i, digital_powerdown_i, frequency_update_strobe, go} = 6'h0;
    {pll_lock_raw_i, interp_overflow_raw_i, reg_wr_i, reg_rd_i} = 4'h0;
    {profile_select_i, reg_addr_i, reg_wdata_i, nw} = 42'h0;
    waitc(6);
    rst_n_i <= 1'b1;
    wr(`UDCP_REG_DIV, 32'h6);
    hw_reset_i <= 1'b1;
    waitc(4);
    wr(`UDCP_REG_DIV, 32'h9);
    hw_reset_i <= 1'b0;
    waitc(4);
    rd(`UDCP_REG_DIV, 32'h4);
    rd(`UDCP_REG_CTRL, 32'h0);
    rd(4'h3, 32'h0);
    rd(`UDCP_REG_STATUS, 32'h20);
    wr(`UDCP_REG_TW0, 32'hc0de_0001);
    wr(`UDCP_REG_TW1, 32'h1234_5678);
    rd(`UDCP_REG_TW1, 32'h1234_5678);
    for (int v = 1; v >= 0; v--) begin
      {pll_lock_raw_i, interp_overflow_raw_i, diff_ref_clock_in_select_i} <= {3{v[0]}};
      waitc(4);
      check({pll_lock_o, interp_overflow_o, ref_clock_in_diff_mode_o}, {3{v[0]}});
    end
    for (int m = 0; m < 4; m++) begin
      wr(`UDCP_REG_CTRL, m);
      waitc(4);
      check({i_path_en_o, q_path_en_o, dds_en_o, modulator_en_o, post_stages_en_o},
        en_tab[m]);
      check(data_clock_or_update_pin_oe_o, m != 1);
    end
    wr(`UDCP_REG_CTRL, 32'h1);
    waitc(4);
    check(acc_tuning_word_o, 32'h0);
    frequency_update_strobe <= 1'b1;
    waitc(20);
    frequency_update_strobe <= 1'b0;
    waitc(20);
    check(acc_tuning_word_o, 32'hc0de_0001);
    profile_select_i <= 2'h1;
    waitc(6);
    check(acc_tuning_word_o, 32'h1234_5678);
    wr(`UDCP_REG_CTRL, 32'h0);
    waitc(4);
    per(8);
    burst(4'h6, 3);
    wr(`UDCP_REG_CTRL, 32'h2);
    idac = 1;
    waitc(4);
    burst(4'h3, 3);
    wr(`UDCP_REG_DIV, 32'h3);
    per(6);
    digital_powerdown_i <= 1'b1;
    wr(`UDCP_REG_CTRL, 32'h8);
    waitc(12);
    check(pll_keep_o, 1'b1);
    n = 0;
    // A running data clock is high for part of any 40 cycles; a stopped one parks low.
    repeat (40) begin
      @(negedge ref_clk_i);
      if (data_clock_or_update_pin_o !== 1'b0) n++;
    end
    check(n, 0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
